// file: crs_pkg.sv
/*
 * Constants, timing counts and carrier structs for the chip reset sequencer.
 * Assumes a single 100 MHz clock; typical times are converted to cycles here.
 */
// Summary of operation
// - Low reset pin holds reset, high releases
// - After processing, CPU runs on fast oscillator
// - First release, monitor on: 0.672/0.832 ms
// - First release, monitor off: 0.399/0.519 ms
// - Later releases, monitor on: 0.531/0.675 ms
// - Later releases, monitor off: 0.259/0.362 ms
// - Power-up adds stabilization wait before processing
// - Dual-mode pad floats on pin/power-on reset
// - Other resets pull dual-mode pad high
// - All other pads float during reset
// - Watchdog reset also resets the watchdog
// - CPU clock gated off during reset
// - Crystal stopped, crystal pins become inputs
// - External clock ignored, pin becomes input
// - Monitor runs only if it caused reset
// - Internal fault resets release by themselves
// - PC loaded from vector at locations 0,1
// - Opcode ff is illegal, raises reset
package crs_pkg;

	localparam int unsigned CLK_HZ      = 100_000_000;
	// Times in nanoseconds, as printed
	localparam int unsigned T_FIRST_LVD_NS  = 672_000;
	localparam int unsigned T_FIRST_OFF_NS  = 399_000;
	localparam int unsigned T_LATER_LVD_NS  = 531_000;
	localparam int unsigned T_LATER_OFF_NS  = 259_000;
	localparam int unsigned T_STAB_NS       = 990_000;
	// Upper bounds, kept for reference only
	localparam int unsigned T_FIRST_LVD_MAX_NS = 832_000;
	localparam int unsigned T_FIRST_OFF_MAX_NS = 519_000;
	localparam int unsigned T_LATER_LVD_MAX_NS = 675_000;
	localparam int unsigned T_LATER_OFF_MAX_NS = 362_000;
	localparam int unsigned T_STAB_MAX_NS      = 2_300_000;

	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

	// Typical times as cycle counts, rounded up
	localparam int unsigned CYC_FIRST_LVD = (T_FIRST_LVD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_FIRST_OFF = (T_FIRST_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_LATER_LVD = (T_LATER_LVD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_LATER_OFF = (T_LATER_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_STAB      = (T_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned CNT_W = 18;

	localparam logic [15:0] RESET_VEC_LO_ADDR = 16'h0000;
	localparam logic [15:0] RESET_VEC_HI_ADDR = 16'h0001;
	localparam logic [7:0]  ILLEGAL_OPCODE    = 8'hff;

	// Reset source vector
	typedef struct packed {
		logic pin;
		logic por;
		logic supply_voltage_monitor;
		logic wdt;
		logic ill;
		logic par;
		logic iam;
	} crs_src_s;

	// Clock and pad controls toward the chip
	typedef struct packed {
		logic cpu_clk_en;
		logic fast_osc_sel;
		logic crystal_osc_en;
		logic crystal_pins_input;
		logic ext_clk_valid;
		logic monitor_run;
		logic pads_hiz;
		logic dual_pad_hiz;
		logic dual_pad_pullup;
	} crs_ctl_s;

endpackage : crs_pkg

// file: crs_delay_counter.sv
/*
 * Down-counter that times one wait and flags its end.
 * Assumes load and count come from the sequencer in the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module crs_delay_counter #(
	parameter int unsigned W = 18
) (
	input  wire logic         clock_i,
	input  wire logic         reset_n_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic              done_o
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         done_r;
	logic         done_nxt;

	// Load wins; count down to zero, flag done at zero
	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (load_i) begin
			cnt_nxt = value_i;
		end else if (cnt_r != '0) begin
			cnt_nxt  = cnt_r - 1'b1;
			done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			cnt_r  <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done_o = done_r;
endmodule : crs_delay_counter
`default_nettype wire

// file: crs_sequencer.sv
/*
 * Chip reset sequencer: merges reset sources, times reset processing,
 * then releases the CPU on the fast internal oscillator.
 * Assumes all source inputs are synchronous to clock_i; reset_n_i is the
 * power-up reset of this logic itself.
 */
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer #(
	parameter int unsigned CYC_FIRST_LVD = crs_pkg::CYC_FIRST_LVD,
	parameter int unsigned CYC_FIRST_OFF = crs_pkg::CYC_FIRST_OFF,
	parameter int unsigned CYC_LATER_LVD = crs_pkg::CYC_LATER_LVD,
	parameter int unsigned CYC_LATER_OFF = crs_pkg::CYC_LATER_OFF,
	parameter int unsigned CYC_STAB      = crs_pkg::CYC_STAB
) (
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	input  wire logic             ext_reset_n_i,
	input  wire logic             por_n_i,
	input  wire logic             monitor_trip_i,
	input  wire logic             monitor_enable_i,
	input  wire logic             wdt_overflow_i,
	input  wire logic             opcode_valid_i,
	input  wire logic [7:0]       opcode_i,
	input  wire logic             ram_parity_err_i,
	input  wire logic             illegal_access_i,
	output logic                  cpu_reset_n_o,
	output logic                  wdt_reset_o,
	output logic                  load_vector_o,
	output logic [15:0]           vector_lo_addr_o,
	output logic [15:0]           vector_hi_addr_o,
	output crs_pkg::crs_ctl_s     ctl_o,
	output crs_pkg::crs_src_s     cause_o
);
	typedef enum logic [2:0] {
		ST_RESET,
		ST_STAB,
		ST_PROC,
		ST_RUN
	} crs_state_e;

	localparam int unsigned W = crs_pkg::CNT_W;

	crs_state_e        state_r, state_nxt;
	crs_pkg::crs_src_s cause_r, cause_nxt;
	logic              por_seen_r, por_seen_nxt;
	logic              first_por_r, first_por_nxt;
	logic              power_up_r, power_up_nxt;
	logic              wdt_rst_r, wdt_rst_nxt;
	logic              cpu_rst_n_r, cpu_rst_n_nxt;
	logic              load_vec_r, load_vec_nxt;
	crs_pkg::crs_ctl_s ctl_r, ctl_nxt;
	logic              cnt_load;
	logic [W-1:0]      cnt_val;
	logic              cnt_done;
	crs_pkg::crs_src_s live;
	logic              any_live;

	// Processing delay picked from power-on history and monitor use
	function automatic logic [W-1:0] proc_cycles(input logic first, input logic lvd_on);
		int unsigned c;
		c = first ? (lvd_on ? CYC_FIRST_LVD : CYC_FIRST_OFF)
		          : (lvd_on ? CYC_LATER_LVD : CYC_LATER_OFF);
		return c[W-1:0];
	endfunction : proc_cycles

	// Live levels of every source; fault pulses are latched below
	always_comb begin
		live     = '0;
		live.pin = !ext_reset_n_i;
		live.por = !por_n_i;
		live.supply_voltage_monitor = monitor_trip_i & monitor_enable_i;
		live.wdt = wdt_overflow_i;
		live.ill = opcode_valid_i && (opcode_i == crs_pkg::ILLEGAL_OPCODE);
		live.par = ram_parity_err_i;
		live.iam = illegal_access_i;
	end

	assign any_live = |live;

	crs_delay_counter #(
		.W (W)
	) u_delay (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.load_i    (cnt_load),
		.value_i   (cnt_val),
		.done_o    (cnt_done)
	);

	// Sequencer: any new source restarts from ST_RESET
	always_comb begin
		state_nxt     = state_r;
		cause_nxt     = cause_r;
		por_seen_nxt  = por_seen_r;
		first_por_nxt = first_por_r;
		power_up_nxt  = power_up_r;
		wdt_rst_nxt   = 1'b0;
		cnt_load      = 1'b0;
		cnt_val       = '0;
		load_vec_nxt  = 1'b0;
		if (any_live) begin
			state_nxt = ST_RESET;
			if (state_r == ST_RUN || state_r != ST_RESET) begin
				cause_nxt = live;
			end else begin
				cause_nxt = cause_r | live;
			end
			if (live.wdt) begin
				wdt_rst_nxt = 1'b1;
			end
			if (live.por) begin
				if (por_seen_r) begin
					first_por_nxt = 1'b0;
				end
				power_up_nxt = 1'b1;
			end
		end else begin
			unique case (state_r)
				ST_RESET: begin
					// Release from last deasserted source
					if (cause_r.por && !por_seen_r) begin
						por_seen_nxt = 1'b1;
					end
					if (power_up_r) begin
						state_nxt = ST_STAB;
						cnt_load  = 1'b1;
						cnt_val   = CYC_STAB[W-1:0];
					end else begin
						state_nxt = ST_PROC;
						cnt_load  = 1'b1;
						cnt_val   = proc_cycles(first_por_r, monitor_enable_i);
					end
				end
				ST_STAB: begin
					if (cnt_done) begin
						power_up_nxt = 1'b0;
						state_nxt    = ST_PROC;
						cnt_load     = 1'b1;
						cnt_val      = proc_cycles(first_por_r, monitor_enable_i);
					end
				end
				ST_PROC: begin
					if (cnt_done) begin
						state_nxt    = ST_RUN;
						load_vec_nxt = 1'b1;
						if (por_seen_r) begin
							first_por_nxt = 1'b0;
						end
					end
				end
				ST_RUN: begin
				end
				default: state_nxt = ST_RESET;
			endcase
		end
		cpu_rst_n_nxt = (state_nxt == ST_RUN);
	end

	// Clock and pad controls follow the next state
	always_comb begin
		logic in_reset;
		logic pin_or_por;
		in_reset   = (state_nxt != ST_RUN);
		pin_or_por = cause_nxt.pin | cause_nxt.por;
		ctl_nxt                    = '0;
		ctl_nxt.cpu_clk_en         = !in_reset;
		ctl_nxt.fast_osc_sel       = 1'b1;
		ctl_nxt.crystal_osc_en     = 1'b0;
		ctl_nxt.crystal_pins_input = 1'b1;
		ctl_nxt.ext_clk_valid      = 1'b0;
		ctl_nxt.monitor_run        = in_reset ? cause_nxt.supply_voltage_monitor : monitor_enable_i;
		ctl_nxt.pads_hiz           = in_reset;
		ctl_nxt.dual_pad_hiz       = in_reset && pin_or_por;
		ctl_nxt.dual_pad_pullup    = !(in_reset && pin_or_por);
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_r     <= ST_RESET;
			// Power-up of this logic counts as the first power-on release
			cause_r     <= '{por: 1'b1, default: 1'b0};
			por_seen_r  <= 1'b0;
			first_por_r <= 1'b1;
			power_up_r  <= 1'b1;
			wdt_rst_r   <= 1'b0;
			cpu_rst_n_r <= 1'b0;
			load_vec_r  <= 1'b0;
			// Pads float, crystal off, fast clock picked while held
			ctl_r       <= '{fast_osc_sel: 1'b1, crystal_pins_input: 1'b1, pads_hiz: 1'b1,
			                 dual_pad_hiz: 1'b1, default: 1'b0};
		end else begin
			state_r     <= state_nxt;
			cause_r     <= cause_nxt;
			por_seen_r  <= por_seen_nxt;
			first_por_r <= first_por_nxt;
			power_up_r  <= power_up_nxt;
			wdt_rst_r   <= wdt_rst_nxt;
			cpu_rst_n_r <= cpu_rst_n_nxt;
			load_vec_r  <= load_vec_nxt;
			ctl_r       <= ctl_nxt;
		end
	end

	// Vector addresses are fixed but registered for clean outputs
	always_ff @(posedge clock_i) begin
		vector_lo_addr_o <= crs_pkg::RESET_VEC_LO_ADDR;
		vector_hi_addr_o <= crs_pkg::RESET_VEC_HI_ADDR;
	end

	assign cpu_reset_n_o = cpu_rst_n_r;
	assign wdt_reset_o   = wdt_rst_r;
	assign load_vector_o = load_vec_r;
	assign ctl_o         = ctl_r;
	assign cause_o       = cause_r;
endmodule : crs_sequencer
`default_nettype wire

// file: crs_sequencer_properties.sv
/* Checker for the reset sequencer: timing and pad relations at its ports.
   Assumes it is bound onto crs_sequencer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_properties (
	input wire logic              clock_i,
	input wire logic              reset_n_i,
	input wire logic              ext_reset_n_i,
	input wire logic              wdt_overflow_i,
	input wire logic              opcode_valid_i,
	input wire logic [7:0]        opcode_i,
	input wire logic              ram_parity_err_i,
	input wire logic              cpu_reset_n_o,
	input wire logic              wdt_reset_o,
	input wire logic              load_vector_o,
	input wire logic [15:0]       vector_lo_addr_o,
	input wire logic [15:0]       vector_hi_addr_o,
	input wire crs_pkg::crs_ctl_s ctl_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// Pin low must hold the CPU next cycle
	property p_pin; !ext_reset_n_i |=> !cpu_reset_n_o; endproperty
	a_pin: assert property (p_pin) else $error("cpu ran with pin low");
	property p_gate; !cpu_reset_n_o |-> !ctl_o.cpu_clk_en; endproperty
	a_gate: assert property (p_gate) else $error("cpu clock on in reset");
	property p_xtal; !cpu_reset_n_o |-> !ctl_o.crystal_osc_en && ctl_o.crystal_pins_input && !ctl_o.ext_clk_valid;
	endproperty
	a_xtal: assert property (p_xtal) else $error("clock pins active in reset");
	property p_hiz; $fell(ext_reset_n_i) |=> ctl_o.pads_hiz && ctl_o.dual_pad_hiz; endproperty
	a_hiz: assert property (p_hiz) else $error("pads driven in pin reset");
	property p_wdt; wdt_overflow_i |=> wdt_reset_o ##1 !wdt_reset_o; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not reset");
	property p_pull; wdt_overflow_i |-> ##[1:2] ctl_o.dual_pad_pullup && !ctl_o.dual_pad_hiz; endproperty
	a_pull: assert property (p_pull) else $error("dual pad not pulled up");
	property p_ill; opcode_valid_i && opcode_i == 8'hff |=> !cpu_reset_n_o; endproperty
	a_ill: assert property (p_ill) else $error("illegal opcode ignored");
	// Parity fault reset must come back by itself within a bounded time
	property p_auto; ram_parity_err_i |=> !cpu_reset_n_o ##[1:120] cpu_reset_n_o; endproperty
	a_auto: assert property (p_auto) else $error("fault reset stuck");
	property p_vec; load_vector_o |-> cpu_reset_n_o && vector_lo_addr_o == 16'h0000 && vector_hi_addr_o == 16'h0001;
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector load");
	property p_fast; cpu_reset_n_o |-> ctl_o.fast_osc_sel && ctl_o.cpu_clk_en; endproperty
	a_fast: assert property (p_fast) else $error("cpu not on fast clock");
endmodule : crs_sequencer_properties
bind crs_sequencer crs_sequencer_properties crs_sequencer_properties_inst (.clock_i(clock_i),
	.reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n_i), .wdt_overflow_i(wdt_overflow_i),
	.opcode_valid_i(opcode_valid_i), .opcode_i(opcode_i), .ram_parity_err_i(ram_parity_err_i),
	.cpu_reset_n_o(cpu_reset_n_o), .wdt_reset_o(wdt_reset_o), .load_vector_o(load_vector_o),
	.vector_lo_addr_o(vector_lo_addr_o), .vector_hi_addr_o(vector_hi_addr_o), .ctl_o(ctl_o));
`default_nettype wire

// file: crs_src_model.sv
/* Model of the reset sources: pin, power-on, monitor, watchdog, faults.
   Assumes the caller invokes drive just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module crs_src_model (
	output var logic       ext_reset_n_o,
	output var logic       por_n_o,
	output var logic       trip_o,
	output var logic       mon_en_o,
	output var logic       wdt_o,
	output var logic       op_valid_o,
	output var logic [7:0] op_o,
	output var logic       par_o,
	output var logic       acc_o
);
	// All sources idle at time zero
	initial begin
		{ext_reset_n_o, por_n_o, trip_o, mon_en_o, wdt_o, op_valid_o, par_o, acc_o} = 8'hc0;
		op_o = 8'h00;
	end
	// Raise or drop one source by index
	task automatic drive(input int k, input logic on);
		case (k)
			0: ext_reset_n_o = !on;
			1: por_n_o = !on;
			2: trip_o = on;
			3: wdt_o = on;
			4: {op_valid_o, op_o} = {on, 8'hff};
			5: par_o = on;
			6: acc_o = on;
			7: {op_valid_o, op_o} = {on, 8'hfe};
			default: mon_en_o = on;
		endcase
	endtask : drive
endmodule : crs_src_model
`default_nettype wire

// file: tb_crs_sequencer.sv
/* Testbench for the reset sequencer with shortened delay counts.
   Assumes the source model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_crs_sequencer;
	localparam int FL = 40, FO = 30, LL = 25, LO = 20, ST = 50;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic ext_n, por_n, trip, mon_en, wdt, opv, par, acc, cpu_reset_n_o, wdt_reset_o, load_vector_o;
	logic [7:0] op;
	logic [15:0] vlo, vhi;
	crs_pkg::crs_ctl_s ctl_o;
	crs_pkg::crs_src_s cause_o;
	int failures = 0, samples_checked = 0;
	always #5 clock_i = !clock_i;
	crs_src_model crs_src_model_inst (.ext_reset_n_o(ext_n), .por_n_o(por_n), .trip_o(trip), .mon_en_o(mon_en),
		.wdt_o(wdt), .op_valid_o(opv), .op_o(op), .par_o(par), .acc_o(acc));
	crs_sequencer #(.CYC_FIRST_LVD(FL), .CYC_FIRST_OFF(FO), .CYC_LATER_LVD(LL), .CYC_LATER_OFF(LO),
		.CYC_STAB(ST)) crs_sequencer_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_n),
		.por_n_i(por_n), .monitor_trip_i(trip), .monitor_enable_i(mon_en), .wdt_overflow_i(wdt),
		.opcode_valid_i(opv), .opcode_i(op), .ram_parity_err_i(par), .illegal_access_i(acc),
		.cpu_reset_n_o(cpu_reset_n_o), .wdt_reset_o(wdt_reset_o), .load_vector_o(load_vector_o),
		.vector_lo_addr_o(vlo), .vector_hi_addr_o(vhi), .ctl_o(ctl_o), .cause_o(cause_o));
	task automatic step; @(posedge clock_i); #1; endtask : step
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// Reset state of CPU clock, crystal, external clock and pads
	task automatic in_rst;
		chk({cpu_reset_n_o, ctl_o.cpu_clk_en, ctl_o.crystal_osc_en, ctl_o.crystal_pins_input}, 16'h1);
		chk({ctl_o.ext_clk_valid, ctl_o.pads_hiz}, 16'h1);
	endtask : in_rst
	// Cycles from source drop to CPU release, bounded
	task automatic measure(input int d);
		int n = 0;
		while (cpu_reset_n_o !== 1'b1 && n < 5000) begin
			step;
			n++;
		end
		if (n >= 5000) begin
			failures++;
			report_and_stop;
		end
		chk(n >= d && n <= d + 8, 1'b1);
		chk({load_vector_o, ctl_o.fast_osc_sel, ctl_o.cpu_clk_en}, 16'h7);
		chk(vlo, crs_pkg::RESET_VEC_LO_ADDR);
		chk(vhi, crs_pkg::RESET_VEC_HI_ADDR);
		step;
		chk(load_vector_o, 1'b0);
		$display("test done, %0d cycles", n);
	endtask : measure
	task automatic t_pin(input int d);
		crs_src_model_inst.drive(0, 1'b1);
		step;
		step;
		in_rst;
		chk({ctl_o.dual_pad_hiz, ctl_o.monitor_run, cause_o.pin}, 16'h5);
		repeat (5) step;
		crs_src_model_inst.drive(0, 1'b0);
		measure(d);
	endtask : t_pin
	task automatic t_por;
		crs_src_model_inst.drive(1, 1'b1);
		repeat (5) step;
		chk(ctl_o.dual_pad_hiz, 1'b1);
		crs_src_model_inst.drive(1, 1'b0);
		measure(ST + LO);
	endtask : t_por
	// Mid-run power-up reset brings back the first-release delay
	task automatic t_reinit;
		crs_src_model_inst.drive(8, 1'b0);
		reset_n_i = 1'b0;
		repeat (5) step;
		in_rst;
		chk(ctl_o.dual_pad_hiz, 1'b1);
		reset_n_i = 1'b1;
		measure(ST + FO);
	endtask : t_reinit
	// Watchdog, illegal opcode, parity and access faults
	task automatic t_faults;
		for (int k = 3; k <= 6; k++) begin
			crs_src_model_inst.drive(k, 1'b1);
			step;
			crs_src_model_inst.drive(k, 1'b0);
			chk(wdt_reset_o, k == 3);
			step;
			in_rst;
			chk(cause_o, 16'h1 << (6 - k));
			chk({ctl_o.dual_pad_pullup, ctl_o.dual_pad_hiz, ctl_o.monitor_run}, 16'h4);
			measure(LO - 1);
		end
		crs_src_model_inst.drive(7, 1'b1);
		step;
		crs_src_model_inst.drive(7, 1'b0);
		repeat (3) step;
		chk(cpu_reset_n_o, 1'b1);
	endtask : t_faults
	task automatic t_trip;
		crs_src_model_inst.drive(8, 1'b1);
		crs_src_model_inst.drive(2, 1'b1);
		step;
		step;
		chk({ctl_o.monitor_run, cause_o.supply_voltage_monitor}, 16'h3);
		crs_src_model_inst.drive(2, 1'b0);
		measure(LL);
	endtask : t_trip
	initial begin
		repeat (5) step;
		crs_src_model_inst.drive(8, 1'b1);
		reset_n_i = 1'b1;
		measure(ST + FL);
		t_pin(LL);
		crs_src_model_inst.drive(8, 1'b0);
		t_pin(LO);
		t_por;
		t_faults;
		t_trip;
		t_reinit;
		report_and_stop;
	end
endmodule : tb_crs_sequencer
`default_nettype wire
